//--- hdl/lhp_dram.sv
// Display RAM: one bit per pixel, eight pixels per byte
`timescale 1ns/10ps
module lhp_dram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Single port, read registered
	input  wire logic [AW-1:0] addr,
	input  wire logic          wr_en,
	input  wire logic [DW-1:0] wr_data,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[addr];
		end
	end

endmodule

//--- hdl/lhp_host_port.sv
// Parallel MPU port of the LCD controller with AXI4-Lite side registers
`timescale 1ns/10ps
module lhp_host_port #(
	parameter logic [15:0] BUSY_RESET = lhp_pkg::BUSY_CYCLES_RESET
) (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write channels
	input  wire logic [lhp_pkg::AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [lhp_pkg::AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic      [31:0]                   s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// MPU parallel pins
	input  wire logic                          interface_select_reset,
	input  wire logic                          chip_select_n,
	input  wire logic                          enable_read_n,
	input  wire logic                          read_write_n,
	input  wire logic                          cmd_data_select,
	input  wire logic [lhp_pkg::DATA_W-1:0]    data_in,
	output logic      [lhp_pkg::DATA_W-1:0]    data_out,
	output logic                               data_oe,
	// Display drive side
	output logic      [lhp_pkg::LINE_W-1:0]    first_common_row,
	output logic                               busy
);

	lhp_pkg::lhp_pins_type pins_raw;
	lhp_pkg::lhp_pins_type pins;
	logic [lhp_pkg::PINS_W-1:0] pins_sync;
	assign pins_raw.sel68  = interface_select_reset;
	assign pins_raw.cs_n   = chip_select_n;
	assign pins_raw.strb_a = enable_read_n;
	assign pins_raw.strb_b = read_write_n;
	assign pins_raw.cds    = cmd_data_select;
	assign pins_raw.data   = data_in;
	assign pins            = lhp_pkg::lhp_pins_type'(pins_sync);
	lhp_sync #(
		.W         (lhp_pkg::PINS_W),
		.RESET_VAL (lhp_pkg::PINS_IDLE)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);
	// Port state
	lhp_pkg::lhp_state_type      state;
	lhp_pkg::lhp_state_type      next_state;
	lhp_pkg::lhp_access_type     kind;
	lhp_pkg::lhp_access_type     next_kind;
	logic [lhp_pkg::DATA_W-1:0]  wr_hold;
	logic [lhp_pkg::DATA_W-1:0]  next_wr_hold;
	logic [lhp_pkg::COL_W-1:0]   column;
	logic [lhp_pkg::COL_W-1:0]   next_column;
	logic [lhp_pkg::PAGE_W-1:0]  page;
	logic [lhp_pkg::PAGE_W-1:0]  next_page;
	logic [lhp_pkg::LINE_W-1:0]  next_first_common_row;
	logic [15:0]                 busy_count;
	logic [15:0]                 next_busy_count;
	logic [15:0]                 reject_count;
	logic [15:0]                 next_reject_count;
	logic [lhp_pkg::DATA_W-1:0]  next_data_out;
	logic                        next_data_oe;
	logic                        ram_we;
	logic [lhp_pkg::DATA_W-1:0]  ram_q;
	logic [lhp_pkg::DATA_W-1:0]  status_byte;
	// Register state
	logic [15:0]                 busy_cycles;
	logic [15:0]                 next_busy_cycles;
	logic                        reject_clear;
	// Access decode from synchronised pins
	logic pin_active;
	logic pin_read;
	logic commit;
	lhp_pkg::lhp_access_type pin_kind;

	always_comb begin
		if (pins.sel68) begin
			pin_active = !pins.cs_n && pins.strb_a;
			pin_read   = pins.strb_b;
		end else begin
			pin_active = !pins.cs_n && (!pins.strb_a || !pins.strb_b);
			pin_read   = !pins.strb_a;
		end
		// Select and direction pick one of four access kinds
		pin_kind = lhp_pkg::lhp_access_type'({!pins.cds, !pin_read});
	end

	assign busy   = (busy_count != 16'h0000);
	assign commit = (state == lhp_pkg::ST_OPEN) && !pin_active;

	always_comb begin
		status_byte                         = '0;
		status_byte[lhp_pkg::STAT_BUSY_BIT] = busy;
	end

	// One byte holds eight vertically stacked pixels
	lhp_dram #(
		.AW (lhp_pkg::RAM_AW),
		.DW (lhp_pkg::DATA_W)
	) u_dram (
		.aclk    (aclk),
		.aresetn (aresetn),
		.addr    ({page, column}),
		.wr_en   (ram_we),
		.wr_data (wr_hold),
		.rd_data (ram_q)
	);

	always_comb begin
		next_state            = state;
		next_kind             = kind;
		next_wr_hold          = wr_hold;
		next_column           = column;
		next_page             = page;
		next_first_common_row = first_common_row;
		next_reject_count     = reject_count;
		next_busy_count       = busy ? busy_count - lhp_pkg::BUSY_ONE : busy_count;
		next_data_out         = data_out;
		next_data_oe          = pin_active && pin_read;
		ram_we                = 1'b0;
		// Read data follows the pins while the strobe is open
		if (pin_active && pin_read) begin
			next_data_out = pins.cds ? ram_q : status_byte;
		end
		if (reject_clear) begin
			next_reject_count = '0;
		end
		case (state)
			lhp_pkg::ST_IDLE: begin
				if (pin_active) begin
					next_state   = lhp_pkg::ST_OPEN;
					next_kind    = pin_kind;
					next_wr_hold = pins.data;
				end
			end
			lhp_pkg::ST_OPEN: begin
				// Last sample before the strobe closes is the one kept
				if (pin_active) begin
					next_kind    = pin_kind;
					next_wr_hold = pins.data;
				end else begin
					next_state = lhp_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = lhp_pkg::ST_IDLE;
			end
		endcase
		if (commit) begin
			if (busy && kind != lhp_pkg::ACC_STATUS) begin
				// Count wins over a clear in the same cycle
				next_reject_count = reject_clear ? lhp_pkg::REJECT_ONE
					: reject_count + lhp_pkg::REJECT_ONE;
			end else begin
				case (kind)
					lhp_pkg::ACC_DATA_WR: begin
						ram_we = 1'b1;
						if (column < lhp_pkg::COL_LAST) begin
							next_column = column + lhp_pkg::COL_ONE;
						end
						next_busy_count = busy_cycles;
					end
					lhp_pkg::ACC_DATA_RD: begin
						if (column < lhp_pkg::COL_LAST) begin
							next_column = column + lhp_pkg::COL_ONE;
						end
						next_busy_count = busy_cycles;
					end
					lhp_pkg::ACC_CMD: begin
						if ((wr_hold & lhp_pkg::CMD_LINE_MASK) == lhp_pkg::CMD_LINE_CODE) begin
							next_first_common_row = wr_hold[lhp_pkg::LINE_W-1:0];
						end else if ((wr_hold & lhp_pkg::CMD_PAGE_MASK)
							== lhp_pkg::CMD_PAGE_CODE) begin
							next_page = wr_hold[lhp_pkg::PAGE_W-1:0];
						end else if ((wr_hold & lhp_pkg::CMD_COL_MASK)
							== lhp_pkg::CMD_COL_CODE) begin
							next_column = wr_hold[lhp_pkg::COL_W-1:0];
						end
						next_busy_count = busy_cycles;
					end
					default: begin
						// Status read has no side effect
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state            <= lhp_pkg::ST_IDLE;
			kind             <= lhp_pkg::ACC_STATUS;
			wr_hold          <= '0;
			column           <= '0;
			page             <= '0;
			first_common_row <= '0;
			busy_count       <= '0;
			reject_count     <= '0;
			data_out         <= '0;
			data_oe          <= 1'b0;
		end else begin
			state            <= next_state;
			kind             <= next_kind;
			wr_hold          <= next_wr_hold;
			column           <= next_column;
			page             <= next_page;
			first_common_row <= next_first_common_row;
			busy_count       <= next_busy_count;
			reject_count     <= next_reject_count;
			data_out         <= next_data_out;
			data_oe          <= next_data_oe;
		end
	end

	// AXI4-Lite slave, one write and one read in flight
	logic        aw_take;
	logic        ar_take;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_rvalid;
	logic [1:0]  next_rresp;
	logic [31:0] next_rdata;

	// Address and data are taken together, never one alone
	assign aw_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = aw_take;
	assign s_axi_wready  = aw_take;
	assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_busy_cycles = busy_cycles;
		next_bvalid      = s_axi_bvalid && !s_axi_bready;
		next_bresp       = s_axi_bresp;
		reject_clear     = 1'b0;
		if (aw_take) begin
			next_bvalid = 1'b1;
			next_bresp  = lhp_pkg::RESP_OKAY;
			case (s_axi_awaddr)
				lhp_pkg::REG_BUSY: begin
					if (s_axi_wstrb[0]) begin
						next_busy_cycles[7:0] = s_axi_wdata[7:0];
					end
					if (s_axi_wstrb[1]) begin
						next_busy_cycles[15:8] = s_axi_wdata[15:8];
					end
				end
				lhp_pkg::REG_REJECT: begin
					reject_clear = 1'b1;
				end
				lhp_pkg::REG_STATUS: begin
					next_bresp = lhp_pkg::RESP_OKAY;
				end
				default: begin
					next_bresp = lhp_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp  = s_axi_rresp;
		next_rdata  = s_axi_rdata;
		if (ar_take) begin
			next_rvalid = 1'b1;
			next_rresp  = lhp_pkg::RESP_OKAY;
			next_rdata  = '0;
			case (s_axi_araddr)
				lhp_pkg::REG_STATUS: begin
					next_rdata[lhp_pkg::ST_BUSY_POS]                     = busy;
					next_rdata[lhp_pkg::ST_PAGE_POS +: lhp_pkg::PAGE_W] = page;
					next_rdata[lhp_pkg::ST_COL_POS +: lhp_pkg::COL_W]   = column;
					next_rdata[lhp_pkg::ST_LINE_POS +: lhp_pkg::LINE_W] = first_common_row;
				end
				lhp_pkg::REG_BUSY: begin
					next_rdata[15:0] = busy_cycles;
				end
				lhp_pkg::REG_REJECT: begin
					next_rdata[15:0] = reject_count;
				end
				default: begin
					next_rresp = lhp_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cycles  <= BUSY_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= lhp_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= lhp_pkg::RESP_OKAY;
			s_axi_rdata  <= '0;
		end else begin
			busy_cycles  <= next_busy_cycles;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
		end
	end

endmodule

//--- hdl/lhp_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module lhp_sync #(
	parameter int               W         = 1,
	parameter logic [W-1:0]     RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Pins in, synchronised out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					stage1[i]   <= RESET_VAL[i];
					sync_out[i] <= RESET_VAL[i];
				end else begin
					stage1[i]   <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule

//--- pkg/lhp_pkg.sv
// Constants, types and pin layout shared by the host port design
package lhp_pkg;

	// Data path widths
	localparam int DATA_W = 8;
	localparam int COL_W  = 7;
	localparam int PAGE_W = 2;
	localparam int LINE_W = 5;
	localparam int RAM_AW = PAGE_W + COL_W;

	// Column counter stops here
	localparam logic [COL_W-1:0] COL_LAST = 7'h50;
	localparam logic [COL_W-1:0] COL_ONE  = 7'h01;

	// Command byte encodings
	localparam logic [7:0] CMD_LINE_MASK = 8'he0;
	localparam logic [7:0] CMD_LINE_CODE = 8'hc0;
	localparam logic [7:0] CMD_PAGE_MASK = 8'hfc;
	localparam logic [7:0] CMD_PAGE_CODE = 8'hb8;
	localparam logic [7:0] CMD_COL_MASK  = 8'h80;
	localparam logic [7:0] CMD_COL_CODE  = 8'h00;

	// Status byte layout
	localparam int STAT_BUSY_BIT = 7;

	// Register map, byte addresses
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
	localparam logic [AXI_AW-1:0] REG_BUSY   = 8'h04;
	localparam logic [AXI_AW-1:0] REG_REJECT = 8'h08;

	// Status register fields
	localparam int ST_BUSY_POS = 0;
	localparam int ST_PAGE_POS = 4;
	localparam int ST_COL_POS  = 8;
	localparam int ST_LINE_POS = 16;

	// Reset value and counter steps
	localparam logic [15:0] BUSY_CYCLES_RESET = 16'h0008;
	localparam logic [15:0] REJECT_ONE        = 16'h0001;
	localparam logic [15:0] BUSY_ONE          = 16'h0001;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Access kinds decoded from select and direction
	typedef enum logic [1:0] {
		ACC_DATA_RD = 2'b00,
		ACC_DATA_WR = 2'b01,
		ACC_STATUS  = 2'b10,
		ACC_CMD     = 2'b11
	} lhp_access_type;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_OPEN = 1'b1
	} lhp_state_type;

	// Parallel pins as they arrive, before synchronising
	typedef struct packed {
		logic              sel68;
		logic              cs_n;
		logic              strb_a;
		logic              strb_b;
		logic              cds;
		logic [DATA_W-1:0] data;
	} lhp_pins_type;

	localparam int PINS_W = 13;
	// Deselected, both 80-style strobes idle high
	localparam logic [PINS_W-1:0] PINS_IDLE = 13'h0e00;

endpackage

//--- testbench/lhp_host_port_properties.sv
// Concurrent checks on the host port pins and register bus
`timescale 1ns/10ps
module lhp_host_port_properties (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Register bus
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// Pins
	input wire logic       interface_select_reset,
	input wire logic       chip_select_n,
	input wire logic       enable_read_n,
	input wire logic       read_write_n,
	input wire logic       cmd_data_select,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic [4:0] first_common_row,
	input wire logic       busy
);
	logic       rd_act;
	logic       wr_act;
	logic [3:0] since_cmd;
	logic [3:0] since_any;
	logic [3:0] next_since_cmd;
	logic [3:0] next_since_any;
	assign rd_act = !chip_select_n && (interface_select_reset ? enable_read_n && read_write_n
		: !enable_read_n);
	// Write strobe reads the same in both bus styles
	assign wr_act = !chip_select_n && enable_read_n && !read_write_n;
	// Cycles since the last strobe, saturating so idle time cannot wrap
	always_comb begin
		next_since_cmd = since_cmd + {3'h0, since_cmd != 4'hf};
		next_since_any = since_any + {3'h0, since_any != 4'hf};
		if (wr_act && !cmd_data_select)
			next_since_cmd = 4'h0;
		if (wr_act || rd_act)
			next_since_any = 4'h0;
	end
	always_ff @(posedge aclk) begin
		since_cmd <= aresetn ? next_since_cmd : 4'hf;
		since_any <= aresetn ? next_since_any : 4'hf;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_start;
		$rose(rd_act);
	endsequence
	sequence s_wr_held;
		wr_act [*4];
	endsequence
	a_oe_on_read: assert property (s_rd_start |-> ##[2:4] data_oe)
		else $error("read not driven");
	a_oe_release: assert property ($fell(rd_act) |-> ##[2:4] !data_oe)
		else $error("bus not released");
	a_write_quiet: assert property (s_wr_held |-> !data_oe)
		else $error("driven during write");
	a_status_zero: assert property (data_oe && !chip_select_n && !cmd_data_select
		|-> data_out[6:0] == 7'h00)
		else $error("status low bits set");
	a_line_by_cmd: assert property ($changed(first_common_row) |-> since_cmd < 4'h8)
		else $error("line moved without command");
	a_busy_cause: assert property ($rose(busy) |-> since_any < 4'h8)
		else $error("busy without access");
	a_line_held: assert property (busy && $past(busy) |-> $stable(first_common_row))
		else $error("line moved while busy");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("no write response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule
bind lhp_host_port lhp_host_port_properties i_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .interface_select_reset, .chip_select_n, .enable_read_n, .read_write_n,
	.cmd_data_select, .data_out, .data_oe, .first_common_row, .busy);

//--- testbench/lhp_host_port_tb.sv
// Self-checking bench for the host port: register bus and parallel pins
`timescale 1ns/10ps
module lhp_host_port_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, interface_select_reset, chip_select_n, enable_read_n;
	logic        read_write_n, cmd_data_select, data_oe, busy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, data_in, data_out, q;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, page;
	logic [4:0]  first_common_row, line;
	logic [6:0]  col;
	logic [15:0] rnd;
	logic [7:0]  ram [int];
	int          n_mismatch, n_compared, i;
	lhp_host_port #(.BUSY_RESET(16'h0002)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .interface_select_reset, .chip_select_n, .enable_read_n,
		.read_write_n, .cmd_data_select, .data_in, .data_out, .data_oe, .first_common_row,
		.busy);
	lhp_mpu_model i_mpu (.aclk, .interface_select_reset, .chip_select_n, .enable_read_n,
		.read_write_n, .cmd_data_select, .data_in, .data_out, .data_oe);
	always #5 aclk = ~aclk;
	task automatic close_out;
		if (n_mismatch == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 500) begin
			n_mismatch++;
			close_out;
		end
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] x);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] stat(input logic bz);
		return {11'h0, line, 1'b0, col, 2'h0, page, 3'h0, bz};
	endfunction
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do tick(n); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) tick(n);
		s_axi_bready <= 1'b0;
		chk32({30'h0, s_axi_bresp}, {30'h0, e});
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do tick(n); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) tick(n);
		s_axi_rready <= 1'b0;
		chk32(s_axi_rdata, x);
		chk32({30'h0, s_axi_rresp}, {30'h0, e});
	endtask
	// Pin access plus the reference model of counter, page, line and RAM
	task automatic pin(input logic m, input logic c, input logic r, input logic [7:0] b,
		input logic ok);
		i_mpu.acc(m, c, r, b, q);
		if (ok && c && r)
			chk8(q, ram[{page, col}]);
		if (ok && c && !r)
			ram[{page, col}] = b;
		if (ok && c && col < 7'h50)
			col++;
		if (ok && !c && !r) begin
			if ((b & lhp_pkg::CMD_LINE_MASK) == lhp_pkg::CMD_LINE_CODE)
				line = b[4:0];
			else if ((b & lhp_pkg::CMD_PAGE_MASK) == lhp_pkg::CMD_PAGE_CODE)
				page = b[1:0];
			else if (!b[7])
				col = b[6:0];
		end
	endtask
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{n_mismatch, n_compared} = 64'h0;
		{col, page, line} = 14'h0;
		rnd = 16'h4ebc;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		axi_rd(lhp_pkg::REG_STATUS, stat(1'b0), lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_BUSY, 32'h2, lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_REJECT, 32'h0, lhp_pkg::RESP_OKAY);
		axi_rd(8'h0c, 32'h0, lhp_pkg::RESP_SLVERR);
		axi_wr(8'h0c, 32'hffffffff, lhp_pkg::RESP_SLVERR);
		axi_wr(lhp_pkg::REG_STATUS, 32'hffffffff, lhp_pkg::RESP_OKAY);
		pin(1'b1, 1'b0, 1'b0, 8'hd5, 1'b1);
		chk8({3'h0, first_common_row}, {3'h0, line});
		pin(1'b1, 1'b0, 1'b0, 8'hba, 1'b1);
		pin(1'b1, 1'b0, 1'b0, 8'h4d, 1'b1);
		axi_rd(lhp_pkg::REG_STATUS, stat(1'b0), lhp_pkg::RESP_OKAY);
		for (i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			pin(1'b1, 1'b1, 1'b0, rnd[7:0], 1'b1);
			axi_rd(lhp_pkg::REG_STATUS, stat(1'b0), lhp_pkg::RESP_OKAY);
		end
		pin(1'b0, 1'b0, 1'b0, 8'h4d, 1'b1);
		for (i = 0; i < 5; i++)
			pin(1'b0, 1'b1, 1'b1, 8'h00, 1'b1);
		pin(1'b0, 1'b0, 1'b1, 8'h00, 1'b1);
		chk8(q, 8'h00);
		axi_wr(lhp_pkg::REG_BUSY, 32'h12c, lhp_pkg::RESP_OKAY);
		pin(1'b1, 1'b0, 1'b0, 8'h4d, 1'b1);
		rnd = lfsr(rnd);
		pin(1'b1, 1'b1, 1'b0, rnd[7:0], 1'b0);
		pin(1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
		chk8(q, 8'h80);
		pin(1'b1, 1'b0, 1'b0, 8'hc3, 1'b0);
		chk8({3'h0, first_common_row}, {3'h0, line});
		axi_rd(lhp_pkg::REG_REJECT, 32'h2, lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_STATUS, stat(1'b1), lhp_pkg::RESP_OKAY);
		i = 0;
		while (busy !== 1'b0) tick(i);
		axi_wr(lhp_pkg::REG_BUSY, 32'h2, lhp_pkg::RESP_OKAY);
		pin(1'b1, 1'b1, 1'b1, 8'h00, 1'b1);
		// Unknown command code is accepted and must leave every pointer alone
		pin(1'b1, 1'b0, 1'b0, 8'he5, 1'b1);
		axi_wr(lhp_pkg::REG_REJECT, 32'h0, lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_REJECT, 32'h0, lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_STATUS, stat(1'b0), lhp_pkg::RESP_OKAY);
		// Upper byte lane only: low byte of the busy length must survive
		s_axi_wstrb <= 4'h2;
		axi_wr(lhp_pkg::REG_BUSY, 32'h0000ff05, lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_BUSY, 32'h0000ff02, lhp_pkg::RESP_OKAY);
		// Second reset in mid-run: all registers except the RAM contents fall back to their reset values
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		{col, page, line} = 14'h0;
		repeat (3) @(posedge aclk);
		chk8({3'h0, first_common_row}, {3'h0, line});
		axi_rd(lhp_pkg::REG_STATUS, stat(1'b0), lhp_pkg::RESP_OKAY);
		axi_rd(lhp_pkg::REG_BUSY, 32'h2, lhp_pkg::RESP_OKAY);
		close_out;
	end
endmodule

//--- testbench/lhp_mpu_model.sv
// Microprocessor on the far side of the parallel pins
`timescale 1ns/10ps
module lhp_mpu_model (
	// Clock
	input  wire logic       aclk,
	// Pins toward the port
	output logic            interface_select_reset,
	output logic            chip_select_n,
	output logic            enable_read_n,
	output logic            read_write_n,
	output logic            cmd_data_select,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	logic [7:0] drv;
	// Port wins while it drives; else our byte or a flipped leftover
	assign data_in = data_oe ? data_out : drv;
	initial begin
		interface_select_reset = 1'b1;
		chip_select_n = 1'b1;
		enable_read_n = 1'b0;
		read_write_n = 1'b1;
		cmd_data_select = 1'b0;
		drv = 8'h00;
	end
	task automatic acc(input logic m, input logic c, input logic r, input logic [7:0] b,
		output logic [7:0] q);
		interface_select_reset <= m;
		enable_read_n <= !m;
		read_write_n <= m ? r : 1'b1;
		cmd_data_select <= c;
		chip_select_n <= 1'b0;
		if (!r)
			drv <= b;
		@(posedge aclk);
		if (m)
			enable_read_n <= 1'b1;
		else if (r)
			enable_read_n <= 1'b0;
		else
			read_write_n <= 1'b0;
		repeat (6) @(posedge aclk);
		q = data_oe ? data_out : 8'hxx;
		enable_read_n <= !m;
		read_write_n <= 1'b1;
		@(posedge aclk);
		chip_select_n <= 1'b1;
		drv <= ~drv;
		// Wide gap keeps the full cycle time, so busy is never polled
		repeat (8) @(posedge aclk);
	endtask
endmodule
